// ==== cwp_config_word_protection.sv ====
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

// How it works
// RULE_01: Configuration word lives at address 2007h
// RULE_02: Bit 13 low enables in-circuit debug
// RULE_03: Unimplemented config bits always read one
// RULE_04: Field 11 means no self-write protection
// RULE_05: Field 10 blocks self-writes up to 3FFh
// RULE_06: Field 01 blocks self-writes up to 7FFh
// RULE_07: Field 00 blocks all self-writes
// RULE_08: Bit 6 low enables code protection
// RULE_09: Protected: external writes refused, reads zero
// RULE_10: CPU access ignores code protection entirely
// RULE_11: Bit 5 selects external reset plus pull-up
// RULE_12: Bit 4 low enables power-up timer
// RULE_13: Bit 3 high enables watchdog
// RULE_14: ID words reachable only in program mode
// RULE_15: Programmer leaves debug bit at one normally
// RULE_16: Reset pin plus timer holds reset 64 ms
// RULE_17: Config latched after reset, stable until next
module cwp_config_word_protection
  import cwp_pkg::*;
#(
  parameter int unsigned P_POWERUP_TIMER_CYCLES = CWP_POWERUP_TIMER_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [CWP_PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [CWP_CFG_W-1:0] i_nvm_config_word,
  input wire logic i_cpu_wr_req,
  input wire logic [CWP_ADDR_W-1:0] i_cpu_wr_addr,
  input wire logic i_cpu_rd_req,
  input wire logic [CWP_ADDR_W-1:0] i_cpu_rd_addr,
  input wire logic i_pgm_mode,
  input wire logic i_ext_req,
  input wire logic i_ext_write,
  input wire logic [CWP_ADDR_W-1:0] i_ext_addr,
  input wire logic [CWP_CFG_W-1:0] i_ext_wdata,
  input wire logic [CWP_CFG_W-1:0] i_mem_rdata,
  output cwp_ctrl_s o_controls,
  output logic o_hold_reset,
  output logic o_self_wr_grant,
  output logic o_self_wr_blocked,
  output logic o_cpu_rd_ok,
  output logic o_ext_ack,
  output logic o_ext_refused,
  output logic [CWP_CFG_W-1:0] o_ext_rdata,
  output logic o_ext_mem_wr_en,
  output logic [CWP_ADDR_W-1:0] o_ext_mem_addr,
  output logic [CWP_CFG_W-1:0] o_ext_mem_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cwp_pu_e pu_state_reg;
  logic [CWP_CFG_W-1:0] cfg_reg;
  logic [CWP_POWERUP_TIMER_CNT_W-1:0] powerup_timer_cnt_reg;
  logic wren_reg;
  logic blk_sticky_reg;
  logic [CWP_CFG_W-1:0] id_mem [CWP_ID_NUM];

  // ----------------------------------------------------------------
  // Configuration capture and power-up sequencing
  // ----------------------------------------------------------------
  wire logic [CWP_CFG_W-1:0] cfg_next = i_nvm_config_word | CWP_CFG_UNIMPL; // RULE_03
  wire cwp_ctrl_s ctrl_next = cwp_decode(cfg_next); // RULE_02 RULE_08
  wire logic pu_run = (pu_state_reg == CWP_PU_RUN);
  wire logic powerup_timer_last = (powerup_timer_cnt_reg ==
    CWP_POWERUP_TIMER_CNT_W'(P_POWERUP_TIMER_CYCLES - 1));
  // Timer only matters when the pin acts as external reset
  wire logic need_powerup_timer = ctrl_next.reset_pin_ext & ctrl_next.powerup_timer_en; // RULE_16

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pu_state_reg <= CWP_PU_LOAD;
      cfg_reg <= CWP_CFG_RST;
      o_controls <= cwp_decode(CWP_CFG_RST);
      powerup_timer_cnt_reg <= '0;
      o_hold_reset <= 1'b1;
    end else begin
      case (pu_state_reg)
        CWP_PU_LOAD: begin
          // One capture per reset; later word changes are ignored
          cfg_reg <= cfg_next; // RULE_17
          o_controls <= ctrl_next; // RULE_17 RULE_11 RULE_12 RULE_13
          if (need_powerup_timer) begin
            pu_state_reg <= CWP_PU_COUNT; // RULE_16
          end else begin
            pu_state_reg <= CWP_PU_RUN;
            o_hold_reset <= 1'b0;
          end
        end
        CWP_PU_COUNT: begin
          powerup_timer_cnt_reg <= powerup_timer_cnt_reg + 1'b1;
          if (powerup_timer_last) begin
            pu_state_reg <= CWP_PU_RUN; // RULE_16
            o_hold_reset <= 1'b0;
          end
        end
        default: begin
          pu_state_reg <= CWP_PU_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Self-write protection
  // ----------------------------------------------------------------
  wire logic cpu_wr_prog = (i_cpu_wr_addr <= CWP_PROG_TOP);
  wire logic wrt_protected =
    (o_controls.wrt_sel == CWP_WRT_ALL) ? 1'b1 : // RULE_07
    (o_controls.wrt_sel == CWP_WRT_LOW2K) ?
      (i_cpu_wr_addr <= CWP_LIM_2K) : // RULE_06
    (o_controls.wrt_sel == CWP_WRT_LOW1K) ?
      (i_cpu_wr_addr <= CWP_LIM_1K) : // RULE_05
    1'b0; // RULE_04
  // Code protection deliberately absent from the self-write path
  wire logic cpu_wr_ok = i_cpu_wr_req & pu_run & wren_reg & cpu_wr_prog &
    ~wrt_protected; // RULE_10
  wire logic cpu_wr_bad = i_cpu_wr_req & ~cpu_wr_ok;
  // ID words are not program memory; the CPU never reaches them
  wire logic cpu_rd_ok = i_cpu_rd_req & (i_cpu_rd_addr <= CWP_PROG_TOP); // RULE_14

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_self_wr_grant <= 1'b0;
      o_self_wr_blocked <= 1'b0;
      o_cpu_rd_ok <= 1'b0;
    end else begin
      o_self_wr_grant <= cpu_wr_ok;
      o_self_wr_blocked <= cpu_wr_bad;
      o_cpu_rd_ok <= cpu_rd_ok; // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // External program/verify access
  // ----------------------------------------------------------------
  wire logic ext_prog = (i_ext_addr <= CWP_PROG_TOP);
  wire logic ext_id = (i_ext_addr >= CWP_ID_BASE) &
    (i_ext_addr <= CWP_ID_LAST);
  wire logic ext_cfg = (i_ext_addr == CWP_CFG_ADDR); // RULE_01
  wire logic ext_live = i_ext_req & i_pgm_mode; // RULE_14
  wire logic ext_wr_prog = ext_live & i_ext_write & ext_prog &
    ~o_controls.code_protect; // RULE_09
  wire logic ext_wr_id = ext_live & i_ext_write & ext_id; // RULE_14
  wire logic ext_refuse = i_ext_req & (~i_pgm_mode |
    (i_ext_write & ext_prog & o_controls.code_protect)); // RULE_09
  wire logic [CWP_ID_IDX_W-1:0] id_idx = i_ext_addr[CWP_ID_IDX_W-1:0];
  wire logic [CWP_CFG_W-1:0] ext_rd_val =
    (~i_pgm_mode) ? '0 :
    ext_prog ? (o_controls.code_protect ? '0 : i_mem_rdata) : // RULE_09
    ext_id ? id_mem[id_idx] :
    ext_cfg ? cfg_reg : '0; // RULE_01

  generate
    for (genvar g = 0; g < CWP_ID_NUM; g++) begin : g_id
      // No reset: ID words model non-volatile storage
      always_ff @(posedge i_clock) begin
        if (ext_wr_id && id_idx == CWP_ID_IDX_W'(g)) begin
          id_mem[g] <= i_ext_wdata; // RULE_14
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_ack <= 1'b0;
      o_ext_refused <= 1'b0;
      o_ext_rdata <= '0;
      o_ext_mem_wr_en <= 1'b0;
      o_ext_mem_addr <= '0;
      o_ext_mem_data <= '0;
    end else begin
      o_ext_ack <= i_ext_req;
      o_ext_refused <= ext_refuse;
      o_ext_mem_wr_en <= ext_wr_prog;
      if (i_ext_req) begin
        o_ext_rdata <= i_ext_write ? '0 : ext_rd_val;
        o_ext_mem_addr <= i_ext_addr;
        o_ext_mem_data <= i_ext_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  wire logic apb_acc = i_psel & i_penable;
  wire logic apb_done = apb_acc & o_pready;
  wire logic hit_ctrl = (i_paddr == CWP_CTRL_BADDR);
  wire logic hit_stat = (i_paddr == CWP_STAT_BADDR);
  wire logic hit_cfg = (i_paddr == CWP_CFG_BADDR);
  wire logic apb_err = ~(hit_ctrl | hit_stat | hit_cfg) |
    (hit_cfg & i_pwrite);
  wire logic [31:0] stat_word = {29'h0, i_pgm_mode, blk_sticky_reg,
    o_hold_reset};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {31'h0, wren_reg} :
    hit_stat ? stat_word :
    hit_cfg ? {18'h0, cfg_reg} : 32'h0;
  wire logic wr_ctrl = apb_done & i_pwrite & hit_ctrl;
  wire logic clr_blk = apb_done & i_pwrite & hit_stat &
    i_pwdata[CWP_ST_BLK];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
      wren_reg <= 1'b0;
      blk_sticky_reg <= 1'b0;
    end else begin
      o_pready <= apb_acc & ~o_pready;
      if (apb_acc && !o_pready) begin
        o_prdata <= i_pwrite ? 32'h0 : rd_mux;
        o_pslverr <= apb_err;
      end
      if (wr_ctrl) begin
        wren_reg <= i_pwdata[CWP_CTL_WREN];
      end
      // New blocked write beats a same-cycle clear
      if (cpu_wr_bad) begin
        blk_sticky_reg <= 1'b1;
      end else if (clr_blk) begin
        blk_sticky_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  AST_UNIMPL_ONES: assert property ( // RULE_03
    pu_run |-> ((cfg_reg & CWP_CFG_UNIMPL) == CWP_CFG_UNIMPL))
    else $error("Unimplemented config bits not one");
  AST_DECODE: assert property ( // RULE_02
    pu_run |-> (o_controls.debug_en == ~cfg_reg[CWP_DBG_BIT]) &&
      (o_controls.code_protect == ~cfg_reg[CWP_CP_BIT]) &&
      (o_controls.reset_pin_ext == cfg_reg[CWP_RPIN_BIT]) &&
      (o_controls.powerup_timer_en == ~cfg_reg[CWP_POWERUP_TIMER_BIT]) &&
      (o_controls.wdt_en == cfg_reg[CWP_WDT_BIT]))
    else $error("Decoded controls disagree with config word");
  AST_WRT_OFF: assert property ( // RULE_04
    i_cpu_wr_req && pu_run && wren_reg && cpu_wr_prog &&
      o_controls.wrt_sel == CWP_WRT_OFF |=> o_self_wr_grant)
    else $error("Unprotected self-write not granted");
  AST_WRT_1K: assert property ( // RULE_05
    i_cpu_wr_req && o_controls.wrt_sel == CWP_WRT_LOW1K &&
      i_cpu_wr_addr <= CWP_LIM_1K |=> !o_self_wr_grant && o_self_wr_blocked)
    else $error("Self-write below 400h not blocked");
  AST_WRT_2K: assert property ( // RULE_06
    i_cpu_wr_req && o_controls.wrt_sel == CWP_WRT_LOW2K &&
      i_cpu_wr_addr <= CWP_LIM_2K |=> !o_self_wr_grant)
    else $error("Self-write below 800h not blocked");
  AST_WRT_ALL: assert property ( // RULE_07
    i_cpu_wr_req && o_controls.wrt_sel == CWP_WRT_ALL |=> !o_self_wr_grant)
    else $error("Self-write granted with full protection");
  AST_CP_READ: assert property ( // RULE_09
    i_ext_req && !i_ext_write && ext_prog && o_controls.code_protect
      |=> o_ext_ack && o_ext_rdata == '0)
    else $error("Protected external read returned data");
  AST_CP_WRITE: assert property ( // RULE_09
    i_ext_req && i_ext_write && o_controls.code_protect
      |=> !o_ext_mem_wr_en)
    else $error("Protected external write passed");
  AST_ID_LOCKED: assert property ( // RULE_14
    i_ext_req && !i_pgm_mode |=> o_ext_refused && o_ext_rdata == '0)
    else $error("Access outside program mode not refused");
  AST_HOLD: assert property ( // RULE_16
    pu_state_reg == CWP_PU_COUNT |-> o_hold_reset && o_controls.powerup_timer_en &&
      o_controls.reset_pin_ext)
    else $error("Power-up hold state inconsistent");
  AST_STABLE: assert property ( // RULE_17
    pu_run && $past(pu_run) |-> $stable(o_controls) && $stable(cfg_reg))
    else $error("Controls changed after capture");

endmodule

// ==== cwp_pkg.sv ====
package cwp_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int unsigned CWP_CFG_W = 14;
  localparam int unsigned CWP_ADDR_W = 14;
  localparam logic [13:0] CWP_CFG_ADDR = 14'h2007;
  localparam logic [13:0] CWP_CFG_RST = 14'h3fff;
  localparam logic [13:0] CWP_CFG_UNIMPL = 14'h1387;
  localparam int unsigned CWP_DBG_BIT = 13;
  localparam int unsigned CWP_WRT_HI = 11;
  localparam int unsigned CWP_WRT_LO = 10;
  localparam int unsigned CWP_CP_BIT = 6;
  localparam int unsigned CWP_RPIN_BIT = 5;
  localparam int unsigned CWP_POWERUP_TIMER_BIT = 4;
  localparam int unsigned CWP_WDT_BIT = 3;

  // ----------------------------------------------------------------
  // Self-write protection field and address map
  // ----------------------------------------------------------------
  localparam logic [1:0] CWP_WRT_OFF = 2'h3;
  localparam logic [1:0] CWP_WRT_LOW1K = 2'h2;
  localparam logic [1:0] CWP_WRT_LOW2K = 2'h1;
  localparam logic [1:0] CWP_WRT_ALL = 2'h0;
  localparam logic [13:0] CWP_LIM_1K = 14'h03ff;
  localparam logic [13:0] CWP_LIM_2K = 14'h07ff;
  localparam logic [13:0] CWP_PROG_TOP = 14'h0fff;
  localparam logic [13:0] CWP_ID_BASE = 14'h2000;
  localparam logic [13:0] CWP_ID_LAST = 14'h2003;
  localparam int unsigned CWP_ID_NUM = 4;
  localparam int unsigned CWP_ID_IDX_W = 2;

  // ----------------------------------------------------------------
  // APB map; config word index times four is its byte address
  // ----------------------------------------------------------------
  localparam int unsigned CWP_PADDR_W = 16;
  localparam logic [15:0] CWP_CFG_INDEX = 16'h2007;
  localparam logic [15:0] CWP_CFG_BADDR = {CWP_CFG_INDEX[13:0], 2'b00};
  localparam logic [15:0] CWP_CTRL_BADDR = 16'h0000;
  localparam logic [15:0] CWP_STAT_BADDR = 16'h0004;
  localparam int unsigned CWP_CTL_WREN = 0;
  localparam int unsigned CWP_ST_HOLD = 0;
  localparam int unsigned CWP_ST_BLK = 1;
  localparam int unsigned CWP_ST_PGM = 2;

  // ----------------------------------------------------------------
  // Power-up timer
  // ----------------------------------------------------------------
  localparam int unsigned CWP_POWERUP_TIMER_MS = 64;
  localparam int unsigned CWP_CLK_HZ = 200_000_000;
  localparam int unsigned CWP_POWERUP_TIMER_CYCLES = CWP_POWERUP_TIMER_MS * (CWP_CLK_HZ / 1000);
  localparam int unsigned CWP_POWERUP_TIMER_CNT_W = 24;

  typedef enum logic [1:0] {CWP_PU_LOAD, CWP_PU_COUNT, CWP_PU_RUN} cwp_pu_e;

  typedef struct packed {
    logic debug_en;
    logic reset_pin_ext;
    logic reset_pin_pullup;
    logic powerup_timer_en;
    logic wdt_en;
    logic code_protect;
    logic [1:0] wrt_sel;
  } cwp_ctrl_s;

  function automatic cwp_ctrl_s cwp_decode(input logic [13:0] w);
    cwp_ctrl_s c;
    c.debug_en = ~w[CWP_DBG_BIT];
    c.reset_pin_ext = w[CWP_RPIN_BIT];
    c.reset_pin_pullup = w[CWP_RPIN_BIT];
    c.powerup_timer_en = ~w[CWP_POWERUP_TIMER_BIT];
    c.wdt_en = w[CWP_WDT_BIT];
    c.code_protect = ~w[CWP_CP_BIT];
    c.wrt_sel = w[CWP_WRT_HI:CWP_WRT_LO];
    return c;
  endfunction

endpackage

// ==== cwp_prog_mem_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Program memory seen by the external port
// ----------------------------------------------------------------
module cwp_prog_mem_model (
  input wire logic i_clock,
  input wire logic [13:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [13:0] i_wr_addr,
  input wire logic [13:0] i_wr_data,
  output logic [13:0] o_rdata
);
  logic [13:0] mem [0:4095];
  logic [13:0] churn_reg = 14'h2aaa;

  initial begin
    for (int a = 0; a < 4096; a++) begin
      mem[a] = 14'(a) ^ 14'h1555;
    end
  end

  always @(posedge i_clock) begin
    churn_reg <= ~churn_reg + 14'h1;
    if (i_wr_en && i_wr_addr < 14'h1000) begin
      mem[i_wr_addr[11:0]] <= i_wr_data;
    end
  end

  // No cell above the array: churn so a stale value never passes
  assign o_rdata = (i_addr < 14'h1000) ? mem[i_addr[11:0]] : churn_reg;
endmodule

// ==== config_word_protection_bench.sv ====
`timescale 1ns/1ps

module config_word_protection_bench;
  import cwp_pkg::*;
  localparam int unsigned PW = 20;
  typedef struct {logic [3:0] k; logic [32:0] v; logic m;} cwp_note_s;
  cwp_note_s note_q[$];
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h9de3;
  logic i_clock = 1'h0;
  logic i_reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [13:0] cfg = 14'h3fff;
  logic cpu_wr = 1'h0;
  logic cpu_rd = 1'h0;
  logic [13:0] cpu_wa = 14'h0;
  logic [13:0] cpu_ra = 14'h0;
  logic pgm = 1'h0;
  logic ext_req = 1'h0;
  logic ext_wr = 1'h0;
  logic [13:0] ext_addr = 14'h0;
  logic [13:0] ext_wdata = 14'h0;
  logic [13:0] mem_rdata, ext_rdata, mem_addr, mem_data;
  logic [31:0] prdata;
  logic pready, pslverr, hold, grant, blocked, rd_ok, ack, refused, wr_en;
  cwp_ctrl_s ctl;

  cwp_config_word_protection #(.P_POWERUP_TIMER_CYCLES(PW)) dut (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_nvm_config_word(cfg), .i_cpu_wr_req(cpu_wr),
    .i_cpu_wr_addr(cpu_wa), .i_cpu_rd_req(cpu_rd), .i_cpu_rd_addr(cpu_ra),
    .i_pgm_mode(pgm), .i_ext_req(ext_req), .i_ext_write(ext_wr),
    .i_ext_addr(ext_addr), .i_ext_wdata(ext_wdata), .i_mem_rdata(mem_rdata),
    .o_controls(ctl), .o_hold_reset(hold), .o_self_wr_grant(grant),
    .o_self_wr_blocked(blocked), .o_cpu_rd_ok(rd_ok), .o_ext_ack(ack),
    .o_ext_refused(refused), .o_ext_rdata(ext_rdata),
    .o_ext_mem_wr_en(wr_en), .o_ext_mem_addr(mem_addr),
    .o_ext_mem_data(mem_data));

  cwp_prog_mem_model mem_model (
    .i_clock(i_clock), .i_addr(ext_addr), .i_wr_en(wr_en),
    .i_wr_addr(mem_addr), .i_wr_data(mem_data), .o_rdata(mem_rdata));

  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic void chk(input string s, input logic [32:0] e,
                              input logic [32:0] g);
    check_count++;
    if (e !== g) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // APB writes carry no read data, so only the error bit is compared
  task automatic take(input logic [3:0] k, input logic [32:0] v);
    cwp_note_s n;
    if (note_q.size() == 0) begin
      chk("unexpected result", 33'h0, 33'(k));
      return;
    end
    n = note_q.pop_front();
    if (n.m) v[31:0] = n.v[31:0];
    chk("result kind", 33'(n.k), 33'(k));
    chk("result", n.v, v);
  endtask

  always @(posedge i_clock) begin
    if (i_reset_n === 1'h1 && pready === 1'h1) take(4'h3, {pslverr, prdata});
    if (i_reset_n === 1'h1 && ack === 1'h1)
      take(4'h1, {refused, wr_en, 3'h0, mem_addr, ext_rdata});
    if (i_reset_n === 1'h1 && (grant | blocked) === 1'h1)
      take(4'h2, 33'({grant, blocked}));
  end

  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    note_q.push_back('{4'h3, e, w});
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'h1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'h1 && n < 40);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge i_clock);
  endtask

  task automatic ext(input logic w, input logic [13:0] a,
                     input logic [13:0] d, input logic rf,
                     input logic [13:0] rd);
    note_q.push_back('{4'h1, {rf, w & ~rf & (a < 14'h1000), 3'h0, a, rd},
                       1'h0});
    ext_req <= 1'h1;
    ext_wr <= w;
    ext_addr <= a;
    ext_wdata <= d;
    @(posedge i_clock);
    ext_req <= 1'h0;
    @(posedge i_clock);
  endtask

  task automatic self_wr(input logic [13:0] a, input logic ok);
    note_q.push_back('{4'h2, 33'({ok, ~ok}), 1'h0});
    cpu_wr <= 1'h1;
    cpu_wa <= a;
    @(posedge i_clock);
    cpu_wr <= 1'h0;
    @(posedge i_clock);
  endtask

  task automatic cpu_read(input logic [13:0] a, input logic ok);
    cpu_rd <= 1'h1;
    cpu_ra <= a;
    @(posedge i_clock);
    cpu_rd <= 1'h0;
    @(posedge i_clock);
    chk("cpu read ok", 33'(ok), 33'(rd_ok));
  endtask

  // Input word is inverted after capture to prove it is not re-sampled
  task automatic do_reset(input logic [13:0] c);
    int n;
    n = 0;
    i_reset_n <= 1'h0;
    cfg <= c;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'h1;
    @(posedge i_clock);
    cfg <= ~c;
    repeat (PW + 4) begin
      @(posedge i_clock);
      if (hold === 1'h1) n++;
    end
    chk("hold cycles", 33'((c[5] & ~c[4]) ? PW : 0), 33'(n));
    chk("controls", 33'({~c[13], c[5], c[5], ~c[4], c[3], ~c[6],
        c[11:10]}), 33'(ctl));
    apb(1'h0, 16'h801c, 32'h0, {1'h0, 18'h0, c | 14'h1387});
    apb(1'h0, 16'h0, 32'h0, 33'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [13:0] c;
    logic [13:0] d;
    logic [13:0] wa [6];
    wa = '{14'h3ff, 14'h400, 14'h7ff, 14'h800, 14'hfff, 14'h1000};
    for (int i = 0; i < 4; i++) begin
      c = 14'(rnd());
      c[13] = (i != 3);
      c[11:10] = 2'(i);
      c[6] = i[0];
      if (i == 0) begin
        c[5] = 1'h1;
        c[4] = 1'h0;
      end
      pgm <= 1'h1;
      do_reset(c);
      apb(1'h1, 16'h0, 32'h1, 33'h0);
      for (int j = 0; j < 6; j++) begin
        self_wr(wa[j], wa[j] < 14'h1000 && (c[11:10] == 2'h3 ||
          (c[11:10] == 2'h2 && wa[j] > 14'h3ff) ||
          (c[11:10] == 2'h1 && wa[j] > 14'h7ff)));
      end
      cpu_read(14'h123, 1'h1);
      cpu_read(14'h2001, 1'h0);
      d = 14'(rnd());
      ext(1'h1, 14'h100, d, ~c[6], 14'h0);
      ext(1'h0, 14'h100, 14'h0, 1'h0, c[6] ? d : 14'h0);
      ext(1'h0, 14'h200, 14'h0, 1'h0, c[6] ? 14'h1755 : 14'h0);
      ext(1'h1, 14'h2000 + 14'(i), ~d, 1'h0, 14'h0);
      ext(1'h0, 14'h2000 + 14'(i), 14'h0, 1'h0, ~d);
      ext(1'h0, 14'h2007, 14'h0, 1'h0, c | 14'h1387);
      pgm <= 1'h0;
      ext(1'h0, 14'h100, 14'h0, 1'h1, 14'h0);
      $display("config test %0d done", i);
    end
    apb(1'h0, 16'h40, 32'h0, 33'h100000000);
    apb(1'h1, 16'h801c, 32'h0, 33'h100000000);
    apb(1'h0, 16'h4, 32'h0, 33'h2);
    apb(1'h1, 16'h4, 32'h2, 33'h0);
    apb(1'h0, 16'h4, 32'h0, 33'h0);
    apb(1'h1, 16'h0, 32'h0, 33'h0);
    self_wr(14'h800, 1'h0);
    apb(1'h0, 16'h4, 32'h0, 33'h2);
    apb(1'h0, 16'h801c, 32'h0, {1'h0, 18'h0, c | 14'h1387});
    $display("register test done");
    chk("notes left", 33'h0, 33'(note_q.size()));
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge i_clock);
    bad_count++;
    $display("wrong value watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule
